/* File: rtl/brlc_top.v */
// fifo and isdn basic rate layer 1/layer 2 link controller
`timescale 1ns/1ns
`default_nettype none
`include "brlc_defines.vh"

module brlc_fifo #(
  parameter W = 17,
  parameter D = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire         CLK,
  input  wire         RESET,
  // fill side
  input  wire         IN_VLD,
  output wire         IN_RDY,
  input  wire [W-1:0] IN_DATA,
  // drain side
  output wire         OUT_VLD,
  input  wire         OUT_RDY,
  output wire [W-1:0] OUT_DATA
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;
  assign IN_RDY   = (cnt_q != D[AW:0]);
  assign OUT_VLD  = (cnt_q != {(AW+1){1'b0}});
  assign OUT_DATA = mem_q[rd_q];
  assign push = IN_VLD & IN_RDY;
  assign pop  = OUT_VLD & OUT_RDY;
  always @(posedge CLK) begin
    if (push)
      mem_q[wr_q] <= IN_DATA;
  end
  always @(posedge CLK) begin
    if (RESET) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

module brlc_top #(
  parameter DBIT_CYC = `BRLC_DBIT_CYC,
  parameter T200_CYC = `BRLC_T200_CYC,
  parameter FIFO_D   = 16
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // port configuration; only NT_MODE is sampled while reset is high, the others are used live
  input  wire        NT_MODE,
  input  wire        ACT_REQ,
  input  wire        DEACT_REQ,
  input  wire [6:0]  PKT_TEI,
  // line receive pattern detector
  input  wire [2:0]  RX_INFO,
  input  wire        RX_LOSS,
  // line transmit pattern select
  output reg  [2:0]  TX_INFO,
  output reg         TX_A,
  // layer 1 report
  output reg  [7:0]  L1_STATUS,
  output reg         STATE_CHANGE_REPORT,
  // received lapd frame headers
  input  wire        RX_FRM_VLD,
  input  wire        RX_FCS_OK,
  input  wire [5:0]  RX_SAPI,
  input  wire [6:0]  RX_TEI,
  input  wire [3:0]  RX_TYPE,
  input  wire [6:0]  RX_AI,
  // transmitted lapd frame headers
  output reg         TX_VLD,
  input  wire        TX_RDY,
  output reg  [5:0]  TX_SAPI,
  output reg  [6:0]  TX_TEI,
  output reg  [3:0]  TX_TYPE,
  // frames passed to the host
  output reg         RX_ACCEPT,
  output reg  [1:0]  RX_CLASS,
  output reg  [6:0]  RX_ACC_TEI,
  // layer 2 report
  output reg  [31:0] L2_STATES,
  output reg         LINK_ERROR_REPORT,
  output reg  [6:0]  ERR_TEI,
  output reg         TX_OVERFLOW
);
  localparam NE = `BRLC_NTEI;
  reg        nt_q;
  reg [3:0]  l1_q;
  reg [3:0]  l1_d;
  // layer 1 sequencing
  always @* begin
    l1_d = l1_q;
    if (nt_q) begin
      case (l1_q)
        `BRLC_G1:
          if (ACT_REQ || RX_INFO == `BRLC_INFO1)
            l1_d = `BRLC_G2;
        `BRLC_G2:
          if (DEACT_REQ)
            l1_d = `BRLC_G4;
          else if (RX_INFO == `BRLC_INFO3)
            l1_d = `BRLC_G3;
        `BRLC_G3:
          if (DEACT_REQ)
            l1_d = `BRLC_G4;
          else if (RX_LOSS || RX_INFO != `BRLC_INFO3)
            l1_d = `BRLC_G2;
        `BRLC_G4:
          if (RX_INFO == `BRLC_INFO0)
            l1_d = `BRLC_G1;
        default:
          l1_d = `BRLC_G1;
      endcase
    end else begin
      case (l1_q)
        `BRLC_F3:
          if (RX_INFO != `BRLC_INFO0)
            l1_d = `BRLC_F5;
          else if (ACT_REQ)
            l1_d = `BRLC_F4;
        `BRLC_F4:
          if (RX_INFO != `BRLC_INFO0)
            l1_d = `BRLC_F5;
        `BRLC_F5:
          if (RX_INFO == `BRLC_INFO2)
            l1_d = `BRLC_F6;
          else if (RX_INFO == `BRLC_INFO4)
            l1_d = `BRLC_F7;
        `BRLC_F6:
          if (RX_LOSS)
            l1_d = `BRLC_F8;
          else if (RX_INFO == `BRLC_INFO4)
            l1_d = `BRLC_F7;
          else if (RX_INFO == `BRLC_INFO0)
            l1_d = `BRLC_F3;
        `BRLC_F7:
          if (RX_LOSS)
            l1_d = `BRLC_F8;
          else if (RX_INFO == `BRLC_INFO0)
            l1_d = `BRLC_F3;
        `BRLC_F8:
          if (RX_LOSS)
            l1_d = `BRLC_F8;
          else if (RX_INFO == `BRLC_INFO2)
            l1_d = `BRLC_F6;
          else if (RX_INFO == `BRLC_INFO4)
            l1_d = `BRLC_F7;
          else if (RX_INFO == `BRLC_INFO0)
            l1_d = `BRLC_F3;
        default:
          l1_d = `BRLC_F3;
      endcase
    end
  end
  // pattern chosen from the state the machine enters
  reg [2:0] tx_info_d;
  always @* begin
    tx_info_d = `BRLC_INFO0;
    if (nt_q) begin
      if (l1_d == `BRLC_G2)
        tx_info_d = `BRLC_INFO2;
      else if (l1_d == `BRLC_G3)
        tx_info_d = `BRLC_INFO4;
    end else begin
      if (l1_d == `BRLC_F4)
        tx_info_d = `BRLC_INFO1;
      else if (l1_d == `BRLC_F6 || l1_d == `BRLC_F7)
        tx_info_d = `BRLC_INFO3;
    end
  end
  wire l1_up = nt_q ? (l1_q == `BRLC_G3) : (l1_q == `BRLC_F7);
  always @(posedge CLK) begin
    if (RESET) begin
      nt_q                <= NT_MODE;
      l1_q                <= 4'h0;
      TX_INFO             <= `BRLC_INFO0;
      TX_A                <= 1'b0;
      L1_STATUS           <= 8'h00;
      STATE_CHANGE_REPORT <= 1'b0;
    end else begin
      l1_q                <= l1_d;
      TX_INFO             <= tx_info_d;
      TX_A                <= nt_q & (l1_d == `BRLC_G3);
      L1_STATUS           <= {nt_q, 3'h0, l1_d};
      STATE_CHANGE_REPORT <= (l1_d != l1_q);
    end
  end

  // d-channel bit pacing
  reg [12:0] dcnt_q;
  wire       dtick = (dcnt_q == 13'h0000);
  always @(posedge CLK) begin
    if (RESET)
      dcnt_q <= 13'h0000;
    else
      dcnt_q <= dtick ? DBIT_CYC[12:0] - 1'b1 : dcnt_q - 1'b1;
  end

  // transmit queue: one header per d-channel slot
  reg        q_vld;
  reg [16:0] q_data;
  wire       q_rdy;
  wire       f_vld;
  wire [16:0] f_data;
  wire       f_rdy = dtick & (~TX_VLD | TX_RDY);
  brlc_fifo #(.W(17), .D(FIFO_D), .AW(4)) u_fifo (
    .CLK      (CLK),
    .RESET    (RESET),
    .IN_VLD   (q_vld),
    .IN_RDY   (q_rdy),
    .IN_DATA  (q_data),
    .OUT_VLD  (f_vld),
    .OUT_RDY  (f_rdy),
    .OUT_DATA (f_data)
  );
  always @(posedge CLK) begin
    if (RESET) begin
      TX_VLD  <= 1'b0;
      TX_SAPI <= 6'h00;
      TX_TEI  <= 7'h00;
      TX_TYPE <= 4'h0;
    end else if (f_rdy) begin
      TX_VLD <= f_vld;
      if (f_vld)
        {TX_SAPI, TX_TEI, TX_TYPE} <= f_data;
    end else if (TX_RDY) begin
      TX_VLD <= 1'b0;
    end
  end

  // data-link entries: seven tei slots plus the packet link
  reg [6:0]  tei_q [0:NE-1];
  reg [3:0]  st_q  [0:NE-1];
  reg [NE-1:0] hit;
  reg [NE-1:0] freev;
  genvar g;
  generate
    for (g = 0; g < NE; g = g + 1) begin : g_ent
      always @* begin
        hit[g]   = (st_q[g] >= `BRLC_L2_ASGN) && (tei_q[g] == RX_TEI);
        freev[g] = (st_q[g] == `BRLC_L2_UNASG);
      end
    end
  endgenerate
  reg [2:0] hit_ix;
  reg [2:0] free_ix;
  reg       any_free;
  reg       pend_mgmt;
  integer   k;
  integer   j;
  always @* begin
    hit_ix    = 3'h0;
    free_ix   = 3'h0;
    any_free  = 1'b0;
    pend_mgmt = 1'b0;
    for (k = NE - 1; k >= 0; k = k - 1) begin
      if (hit[k])
        hit_ix = k[2:0];
      if (freev[k]) begin
        free_ix  = k[2:0];
        any_free = 1'b1;
      end
      if (st_q[k] == `BRLC_L2_AWASG)
        pend_mgmt = 1'b1;
    end
  end
  reg [3:0] pkt_st_q;

  // receive classification
  wire rx_ok   = RX_FRM_VLD & RX_FCS_OK;
  wire is_mgmt = (RX_SAPI == `BRLC_SAPI_MGMT) &&
                 (RX_TEI == `BRLC_TEI_GROUP);
  wire is_bc   = (RX_SAPI == `BRLC_SAPI_CALL) &&
                 (RX_TEI == `BRLC_TEI_GROUP);
  wire is_call = (RX_SAPI == `BRLC_SAPI_CALL) &&
                 (RX_TEI != `BRLC_TEI_GROUP) && (|hit);
  wire is_pkt  = (RX_SAPI == `BRLC_SAPI_PKT) &&
                 (RX_TEI != `BRLC_TEI_GROUP) &&
                 (RX_TEI == PKT_TEI);
  wire [3:0] cur_st = is_pkt ? pkt_st_q : st_q[hit_ix];

  // establishment timer, one outstanding mode-set at a time
  reg [27:0] t_q;
  reg        t_on_q;
  reg [2:0]  t_ix_q;
  reg [1:0]  retry_q;
  reg [6:0]  next_tei_q;
  reg        boot_q;
  wire       t_exp = t_on_q && (t_q == 28'h0000000);

  always @(posedge CLK) begin
    if (RESET) begin
      for (j = 0; j < NE; j = j + 1) begin
        tei_q[j] <= 7'h00;
        st_q[j]  <= `BRLC_L2_UNASG;
      end
      pkt_st_q          <= `BRLC_L2_ASGN;
      t_q               <= 28'h0000000;
      t_on_q            <= 1'b0;
      t_ix_q            <= 3'h0;
      retry_q           <= 2'h0;
      next_tei_q        <= `BRLC_TEI_DYN_LO;
      boot_q            <= 1'b1;
      q_vld             <= 1'b0;
      q_data            <= 17'h00000;
      RX_ACCEPT         <= 1'b0;
      RX_CLASS          <= 2'h0;
      RX_ACC_TEI        <= 7'h00;
      LINK_ERROR_REPORT <= 1'b0;
      ERR_TEI           <= 7'h00;
      TX_OVERFLOW       <= 1'b0;
    end else begin
      q_vld             <= 1'b0;
      RX_ACCEPT         <= 1'b0;
      LINK_ERROR_REPORT <= 1'b0;
      // a full queue drops the header and flags it
      TX_OVERFLOW       <= q_vld & ~q_rdy;
      if (t_on_q && !t_exp)
        t_q <= t_q - 1'b1;
      if (t_exp) begin
        if (retry_q == `BRLC_N200) begin
          // recovery exhausted, fall back and tell the host
          st_q[t_ix_q]      <= `BRLC_L2_ASGN;
          t_on_q            <= 1'b0;
          LINK_ERROR_REPORT <= 1'b1;
          ERR_TEI           <= tei_q[t_ix_q];
        end else begin
          retry_q <= retry_q + 1'b1;
          t_q     <= T200_CYC[27:0];
          q_vld   <= 1'b1;
          q_data  <= {`BRLC_SAPI_CALL, tei_q[t_ix_q], `BRLC_FT_SABME};
          if (st_q[t_ix_q] == `BRLC_L2_MULTI)
            st_q[t_ix_q] <= `BRLC_L2_TREC;
        end
      end else if (!nt_q && boot_q && l1_up && any_free && !pend_mgmt) begin
        // terminal asks for one tei once layer 1 is up
        boot_q        <= 1'b0;
        st_q[free_ix] <= `BRLC_L2_AWASG;
        q_vld         <= 1'b1;
        q_data        <= {`BRLC_SAPI_MGMT, `BRLC_TEI_GROUP, `BRLC_FT_TREQ};
      end else if (rx_ok) begin
        if (is_mgmt) begin
          if (!nt_q && RX_TYPE == `BRLC_FT_TASG && pend_mgmt) begin
            // slot waiting for assignment takes the tei
            // timer follows the slot that took the tei, not a free one
            for (j = 0; j < NE; j = j + 1) begin
              if (st_q[j] == `BRLC_L2_AWASG) begin
                tei_q[j] <= RX_AI;
                st_q[j]  <= `BRLC_L2_AWEST;
                t_ix_q   <= j[2:0];
              end
            end
            q_vld   <= 1'b1;
            q_data  <= {`BRLC_SAPI_CALL, RX_AI, `BRLC_FT_SABME};
            t_on_q  <= 1'b1;
            t_q     <= T200_CYC[27:0];
            retry_q <= 2'h0;
          end else if (nt_q && RX_TYPE == `BRLC_FT_TREQ && any_free) begin
            // grant sequentially, wrapping inside the dynamic range
            tei_q[free_ix] <= next_tei_q;
            st_q[free_ix]  <= `BRLC_L2_ASGN;
            next_tei_q     <= (next_tei_q == `BRLC_TEI_DYN_HI) ?
                              `BRLC_TEI_DYN_LO : next_tei_q + 1'b1;
            q_vld  <= 1'b1;
            q_data <= {`BRLC_SAPI_MGMT, `BRLC_TEI_GROUP, `BRLC_FT_TASG};
          end
          RX_ACCEPT  <= 1'b1;
          RX_CLASS   <= 2'h0;
          RX_ACC_TEI <= RX_TEI;
        end else if (is_bc) begin
          RX_ACCEPT  <= (RX_TYPE == `BRLC_FT_UI);
          RX_CLASS   <= 2'h1;
          RX_ACC_TEI <= RX_TEI;
        end else if (is_call || is_pkt) begin
          case (RX_TYPE)
            `BRLC_FT_SABME: begin
              // peer opens the link: acknowledge it
              if (is_pkt)
                pkt_st_q <= `BRLC_L2_MULTI;
              else
                st_q[hit_ix] <= `BRLC_L2_MULTI;
              q_vld  <= 1'b1;
              q_data <= {RX_SAPI, RX_TEI, `BRLC_FT_UA};
            end
            `BRLC_FT_UA: begin
              if (!is_pkt && cur_st == `BRLC_L2_AWEST) begin
                st_q[hit_ix] <= `BRLC_L2_MULTI;
                t_on_q       <= 1'b0;
              end
            end
            `BRLC_FT_RR: begin
              // an answer during recovery closes it
              if (!is_pkt && cur_st == `BRLC_L2_TREC) begin
                st_q[hit_ix] <= `BRLC_L2_MULTI;
                t_on_q       <= 1'b0;
              end
            end
            `BRLC_FT_DISC, `BRLC_FT_DM: begin
              if (is_pkt)
                pkt_st_q <= `BRLC_L2_ASGN;
              else
                st_q[hit_ix] <= `BRLC_L2_ASGN;
              if (RX_TYPE == `BRLC_FT_DISC) begin
                q_vld  <= 1'b1;
                q_data <= {RX_SAPI, RX_TEI, `BRLC_FT_UA};
              end
            end
            `BRLC_FT_I: begin
              if (cur_st == `BRLC_L2_MULTI) begin
                RX_ACCEPT  <= 1'b1;
                RX_CLASS   <= is_pkt ? 2'h3 : 2'h2;
                RX_ACC_TEI <= RX_TEI;
                q_vld      <= 1'b1;
                q_data     <= {RX_SAPI, RX_TEI, `BRLC_FT_RR};
              end else begin
                // not established: refuse with disconnect mode
                q_vld  <= 1'b1;
                q_data <= {RX_SAPI, RX_TEI, `BRLC_FT_DM};
              end
            end
            default: begin
              RX_ACCEPT  <= (RX_TYPE == `BRLC_FT_UI);
              RX_CLASS   <= is_pkt ? 2'h3 : 2'h2;
              RX_ACC_TEI <= RX_TEI;
            end
          endcase
        end
      end
      // layer 1 loss drops established tei-slot links back to the assigned state while the timer is off
      if (!l1_up && !t_on_q) begin
        for (j = 0; j < NE; j = j + 1) begin
          if (st_q[j] == `BRLC_L2_MULTI)
            st_q[j] <= `BRLC_L2_ASGN;
        end
      end
    end
  end

  // data-link states exported per entry
  generate
    for (g = 0; g < NE; g = g + 1) begin : g_rep
      always @(posedge CLK) begin
        if (RESET)
          L2_STATES[4*g+3:4*g] <= `BRLC_L2_UNASG;
        else
          L2_STATES[4*g+3:4*g] <= st_q[g];
      end
    end
  endgenerate
  always @(posedge CLK) begin
    if (RESET)
      L2_STATES[31:28] <= `BRLC_L2_ASGN;
    else
      L2_STATES[31:28] <= pkt_st_q;
  end
endmodule
`default_nettype wire

/* File: rtl/brlc_defines.vh */
// constants for the isdn basic rate link controller
// Overview of operation
// - idle ports send nothing on the line
// - terminal activation request sends first pattern
// - network pending sends zero frames, A zero
// - synchronized terminal sends operational frames
// - activated network sends data, A set
// - terminal awaits signal while requesting activation
// - identifying state waits for network patterns
// - pending pattern seen: synchronized, send data
// - activated pattern seen: terminal activated
// - framing loss: lost state, resync or deactivate
// - network pending waits for terminal frames
// - terminal frames seen: network activated
// - autonomous sequencing, report each state change
// - lapd frames paced at d-channel rate
// - address 63/127 for layer 2 management
// - address 0/127 is broadcast group
// - sapi 0 with tei 0-126 call control
// - sapi 16 with tei 0-126 packet data
// - information frames only in multi-frame state
// - terminal sends mode-set once tei assigned
// - seven tei entries plus packet link
// - unrecoverable layer 2 error reported to host
// - status byte: bit7 network, state low
// - data-link state 7 means multi-frame
`ifndef BRLC_DEFINES_VH
`define BRLC_DEFINES_VH
// line pattern codes
`define BRLC_INFO0 3'h0
`define BRLC_INFO1 3'h1
`define BRLC_INFO2 3'h2
`define BRLC_INFO3 3'h3
`define BRLC_INFO4 3'h4
// layer 1 state numbers
`define BRLC_F3 4'h3
`define BRLC_F4 4'h4
`define BRLC_F5 4'h5
`define BRLC_F6 4'h6
`define BRLC_F7 4'h7
`define BRLC_F8 4'h8
`define BRLC_G1 4'h1
`define BRLC_G2 4'h2
`define BRLC_G3 4'h3
`define BRLC_G4 4'h4
`define BRLC_NT_BIT 7
// frame types
`define BRLC_FT_I     4'h0
`define BRLC_FT_RR    4'h1
`define BRLC_FT_SABME 4'h4
`define BRLC_FT_DISC  4'h5
`define BRLC_FT_UA    4'h6
`define BRLC_FT_DM    4'h7
`define BRLC_FT_UI    4'h8
`define BRLC_FT_TREQ  4'hA
`define BRLC_FT_TASG  4'hB
// addresses
`define BRLC_SAPI_MGMT 6'h3F
`define BRLC_SAPI_CALL 6'h00
`define BRLC_SAPI_PKT  6'h10
`define BRLC_TEI_GROUP 7'h7F
`define BRLC_TEI_DYN_LO 7'h40
`define BRLC_TEI_DYN_HI 7'h7E
// data-link states
`define BRLC_L2_UNASG 4'h1
`define BRLC_L2_AWASG 4'h2
`define BRLC_L2_ASGN  4'h4
`define BRLC_L2_AWEST 4'h5
`define BRLC_L2_MULTI 4'h7
`define BRLC_L2_TREC  4'h8
// timing
`define BRLC_CLK_HZ   100000000
`define BRLC_DCH_HZ   16000
`define BRLC_DBIT_CYC (`BRLC_CLK_HZ / `BRLC_DCH_HZ)
`define BRLC_T200_MS  1000
`define BRLC_T200_CYC (`BRLC_T200_MS * (`BRLC_CLK_HZ / 1000))
`define BRLC_N200     2'h3
`define BRLC_NTEI     7
`endif

/* File: tb/brlc_checker.sv */
// port assertions for the basic rate link controller
`timescale 1ns/1ns
`default_nettype none
`include "brlc_defines.vh"
module brlc_checker (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RESET,
  // layer 1
  input wire logic [2:0] RX_INFO,
  input wire logic       RX_LOSS,
  input wire logic [2:0] TX_INFO,
  input wire logic       TX_A,
  input wire logic [7:0] L1_STATUS,
  input wire logic       STATE_CHANGE_REPORT,
  // frame headers
  input wire logic       RX_FRM_VLD,
  input wire logic       RX_FCS_OK,
  input wire logic [5:0] RX_SAPI,
  input wire logic [6:0] RX_TEI,
  input wire logic       TX_VLD,
  input wire logic       TX_RDY,
  input wire logic [5:0] TX_SAPI,
  input wire logic [6:0] TX_TEI,
  input wire logic [3:0] TX_TYPE,
  input wire logic       RX_ACCEPT,
  input wire logic [1:0] RX_CLASS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_idle_silent: assert property (
    (L1_STATUS == 8'h03 || L1_STATUS == 8'h81) |-> TX_INFO == 3'h0 && !TX_A)
    else $error("idle port drives line");
  a_req_pattern: assert property (
    L1_STATUS == 8'h04 |-> TX_INFO == 3'h1) else $error("bad request pattern");
  a_pend_pattern: assert property (
    L1_STATUS == 8'h82 |-> TX_INFO == 3'h2 && !TX_A)
    else $error("bad pending pattern");
  a_sync_pattern: assert property (
    (L1_STATUS == 8'h06 || L1_STATUS == 8'h07) |-> TX_INFO == 3'h3)
    else $error("bad terminal frames");
  a_act_pattern: assert property (
    L1_STATUS == 8'h83 |-> TX_INFO == 3'h4 && TX_A)
    else $error("bad activated pattern");
  a_change_report: assert property (
    STATE_CHANGE_REPORT == !$stable(L1_STATUS))
    else $error("state report mismatch");
  a_ident_entry: assert property (
    L1_STATUS == 8'h04 && RX_INFO != 3'h0 |=> L1_STATUS == 8'h05)
    else $error("no identify entry");
  a_loss_enter: assert property (
    L1_STATUS == 8'h07 && RX_LOSS |=> L1_STATUS == 8'h08)
    else $error("no lost framing entry");
  a_fcs_drop: assert property (
    RX_FRM_VLD && !RX_FCS_OK |=> !RX_ACCEPT) else $error("bad frame passed");
  a_hdr_hold: assert property (
    TX_VLD && !TX_RDY |=> TX_VLD && $stable({TX_SAPI, TX_TEI, TX_TYPE}))
    else $error("header not held");
  a_mgmt_addr: assert property (
    RX_ACCEPT && RX_CLASS == 2'h0 |->
      $past(RX_SAPI) == 6'h3F && $past(RX_TEI) == 7'h7F)
    else $error("bad management class");
  a_call_addr: assert property (
    RX_ACCEPT && RX_CLASS == 2'h2 |->
      $past(RX_SAPI) == 6'h00 && $past(RX_TEI) != 7'h7F)
    else $error("bad call class");
  a_pkt_addr: assert property (
    RX_ACCEPT && RX_CLASS == 2'h3 |->
      $past(RX_SAPI) == 6'h10 && $past(RX_TEI) != 7'h7F)
    else $error("bad packet class");
  a_treq_addr: assert property (
    TX_VLD && TX_TYPE == `BRLC_FT_TREQ |-> TX_SAPI == 6'h3F && TX_TEI == 7'h7F)
    else $error("bad request address");
endmodule
bind brlc_top brlc_checker chk_u (.CLK, .RESET, .RX_INFO, .RX_LOSS,
  .TX_INFO, .TX_A, .L1_STATUS, .STATE_CHANGE_REPORT, .RX_FRM_VLD,
  .RX_FCS_OK, .RX_SAPI, .RX_TEI, .TX_VLD, .TX_RDY, .TX_SAPI, .TX_TEI,
  .TX_TYPE, .RX_ACCEPT, .RX_CLASS);
`default_nettype wire

/* File: tb/brlc_peer.sv */
// line-side peer: answers activation and takes headers
`timescale 1ns/1ns
`default_nettype none
module brlc_peer (
  // clock
  input  wire logic       clk,
  // bench control
  input  wire logic       en,
  input  wire logic       nt_dut,
  input  wire logic       stall,
  // line and header handshake
  input  wire logic [2:0] tx_info,
  input  wire logic       tx_vld,
  output wire logic [2:0] rx_info,
  output wire logic       tx_rdy
);
  logic [1:0] st_q = 2'h0;
  logic       rdy_q = 1'b0;
  always @(posedge clk) begin
    if (!en)
      st_q <= 2'h0;
    else if (nt_dut)
      st_q <= (tx_info == 3'h2 || tx_info == 3'h4) ? 2'h3 : st_q;
    else if (st_q == 2'h0 && tx_info == 3'h1)
      st_q <= 2'h1;
    else if (st_q == 2'h1 && tx_info == 3'h3)
      st_q <= 2'h2;
    // slow answer: one wait cycle before each header is taken
    rdy_q <= !stall && tx_vld && !rdy_q;
  end
  assign rx_info = st_q == 2'h1 ? 3'h2 : st_q == 2'h2 ? 3'h4 :
                   st_q == 2'h3 ? 3'h3 : 3'h0;
  assign tx_rdy = rdy_q;
endmodule
`default_nettype wire

/* File: tb/brlc_top_tb.sv */
// self-checking bench for the basic rate link controller
`timescale 1ns/1ns
`default_nettype none
`include "brlc_defines.vh"
module brlc_top_tb;
  logic        clk = 0, rst = 1, nt_mode = 0, act_req = 0, deact = 0;
  logic        rx_loss = 0, frm_vld = 0, fcs_ok = 1, en = 0, stall = 0;
  logic [5:0]  rx_sapi = 0;
  logic [6:0]  rx_tei = 0, rx_ai = 0;
  logic [3:0]  rx_type = 0;
  wire  [2:0]  rx_info, tx_info;
  wire         tx_a, chg, tx_vld, tx_rdy, acc, lerr, ovf_p;
  wire  [7:0]  l1;
  wire  [5:0]  tx_sapi;
  wire  [6:0]  tx_tei, acc_tei, err_tei;
  wire  [3:0]  tx_type;
  wire  [1:0]  cls;
  wire  [31:0] l2;
  int          num_errors = 0, checks = 0;
  logic        ovf = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (ovf_p) ovf <= 1'b1;
  // short counts keep the run brief
  brlc_top #(.DBIT_CYC(8), .T200_CYC(50), .FIFO_D(16)) dut_u (
    .CLK(clk), .RESET(rst), .NT_MODE(nt_mode), .ACT_REQ(act_req),
    .DEACT_REQ(deact), .PKT_TEI(7'h05), .RX_INFO(rx_info),
    .RX_LOSS(rx_loss), .TX_INFO(tx_info), .TX_A(tx_a), .L1_STATUS(l1),
    .STATE_CHANGE_REPORT(chg), .RX_FRM_VLD(frm_vld), .RX_FCS_OK(fcs_ok),
    .RX_SAPI(rx_sapi), .RX_TEI(rx_tei), .RX_TYPE(rx_type), .RX_AI(rx_ai),
    .TX_VLD(tx_vld), .TX_RDY(tx_rdy), .TX_SAPI(tx_sapi), .TX_TEI(tx_tei),
    .TX_TYPE(tx_type), .RX_ACCEPT(acc), .RX_CLASS(cls),
    .RX_ACC_TEI(acc_tei), .L2_STATES(l2), .LINK_ERROR_REPORT(lerr),
    .ERR_TEI(err_tei), .TX_OVERFLOW(ovf_p));
  brlc_peer peer_u (.clk(clk), .en(en), .nt_dut(nt_mode), .stall(stall),
    .tx_info(tx_info), .tx_vld(tx_vld), .rx_info(rx_info), .tx_rdy(tx_rdy));
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // outputs are read just as the edge arrives, before it updates them
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_st(input logic [7:0] s);
    int i;
    for (i = 0; i < 100 && l1 !== s; i++) tick();
    chk(l1, s);
  endtask
  task automatic send(input logic [5:0] s, input logic [6:0] t,
                      input logic [3:0] ty, input logic ok);
    {rx_sapi, rx_tei, rx_type, fcs_ok, frm_vld} <= {s, t, ty, ok, 1'b1};
    tick();
    frm_vld <= 1'b0;
    tick();
  endtask
  task automatic get_tx(input logic [5:0] s, input logic [6:0] t,
                        input logic [3:0] ty);
    int i;
    for (i = 0; i < 400 && !(tx_vld === 1'b1 && tx_rdy === 1'b1); i++)
      tick();
    chk({tx_vld, tx_rdy, tx_sapi, tx_tei, tx_type}, {2'h3, s, t, ty});
    tick();
  endtask
  task automatic do_reset(input logic nt);
    rst <= 1'b1;
    nt_mode <= nt;
    en <= 1'b0;
    tick(16);
    rst <= 1'b0;
    tick(2);
    chk({l1, chg}, {nt, 3'h0, nt ? 4'h1 : 4'h3, 1'b1});
    chk(l2, 32'h41111111);
  endtask
  task automatic te_l1();
    en <= 1'b1;
    act_req <= 1'b1;
    wait_st(8'h04);
    chk({tx_info, chg}, {3'h1, 1'b1});
    wait_st(8'h05);
    wait_st(8'h06);
    chk(tx_info, 3'h3);
    wait_st(8'h07);
  endtask
  task automatic te_l2();
    int i;
    get_tx(6'h3F, 7'h7F, `BRLC_FT_TREQ);
    chk(l2[3:0], `BRLC_L2_AWASG);
    rx_ai <= 7'h40;
    send(6'h3F, 7'h7F, `BRLC_FT_TASG, 1'b1);
    get_tx(6'h00, 7'h40, `BRLC_FT_SABME);
    chk(l2[3:0], `BRLC_L2_AWEST);
    send(6'h00, 7'h40, `BRLC_FT_UA, 1'b0);
    chk({acc, l2[3:0]}, {1'b0, `BRLC_L2_AWEST});
    // no answer: resends, then the link is given up
    for (i = 0; i < 3; i++) get_tx(6'h00, 7'h40, `BRLC_FT_SABME);
    for (i = 0; i < 400 && lerr !== 1'b1; i++) tick();
    chk({lerr, err_tei}, {1'b1, 7'h40});
    tick();
    chk(l2[3:0], `BRLC_L2_ASGN);
  endtask
  task automatic te_lost();
    rx_loss <= 1'b1;
    wait_st(8'h08);
    rx_loss <= 1'b0;
    wait_st(8'h07);
    rx_loss <= 1'b1;
    wait_st(8'h08);
    // silence the peer while loss holds, so the exit is straight to F3
    en <= 1'b0;
    act_req <= 1'b0;
    tick(3);
    chk(l1, 8'h08);
    rx_loss <= 1'b0;
    tick(2);
    chk(l1, 8'h03);
    chk(tx_info, 3'h0);
  endtask
  task automatic nt_l1();
    en <= 1'b1;
    act_req <= 1'b1;
    wait_st(8'h82);
    chk({tx_info, tx_a}, {3'h2, 1'b0});
    wait_st(8'h83);
    chk({tx_info, tx_a}, {3'h4, 1'b1});
    act_req <= 1'b0;
  endtask
  task automatic nt_l2();
    send(6'h3F, 7'h7F, `BRLC_FT_TREQ, 1'b1);
    chk({acc, cls}, {1'b1, 2'h0});
    get_tx(6'h3F, 7'h7F, `BRLC_FT_TASG);
    chk(l2[3:0], `BRLC_L2_ASGN);
    send(6'h00, 7'h40, `BRLC_FT_SABME, 1'b1);
    get_tx(6'h00, 7'h40, `BRLC_FT_UA);
    chk(l2[3:0], `BRLC_L2_MULTI);
    send(6'h00, 7'h40, `BRLC_FT_I, 1'b0);
    chk(acc, 1'b0);
    send(6'h00, 7'h40, `BRLC_FT_I, 1'b1);
    chk({acc, cls, acc_tei}, {1'b1, 2'h2, 7'h40});
    get_tx(6'h00, 7'h40, `BRLC_FT_RR);
    send(6'h00, 7'h7F, `BRLC_FT_UI, 1'b1);
    chk({acc, cls}, {1'b1, 2'h1});
    send(6'h10, 7'h05, `BRLC_FT_I, 1'b1);
    chk(acc, 1'b0);
    get_tx(6'h10, 7'h05, `BRLC_FT_DM);
    send(6'h10, 7'h05, `BRLC_FT_SABME, 1'b1);
    get_tx(6'h10, 7'h05, `BRLC_FT_UA);
    chk(l2[31:28], `BRLC_L2_MULTI);
    send(6'h10, 7'h05, `BRLC_FT_I, 1'b1);
    chk({acc, cls, acc_tei}, {1'b1, 2'h3, 7'h05});
    get_tx(6'h10, 7'h05, `BRLC_FT_RR);
  endtask
  task automatic nt_fill();
    int i;
    int n;
    int idle;
    stall <= 1'b1;
    for (i = 0; i < 20; i++) send(6'h00, 7'h40, `BRLC_FT_I, 1'b1);
    chk(ovf, 1'b1);
    stall <= 1'b0;
    n = 0;
    idle = 0;
    for (i = 0; i < 2000 && idle < 40; i++) begin
      n += (tx_vld && tx_rdy) ? 1 : 0;
      idle = tx_vld ? 0 : idle + 1;
      tick();
    end
    // queue depth plus the header already on the outputs, rest dropped
    chk(n, 17);
  endtask
  task automatic nt_down();
    deact <= 1'b1;
    wait_st(8'h84);
    deact <= 1'b0;
    en <= 1'b0;
    wait_st(8'h81);
  endtask
  initial begin
    do_reset(1'b0);
    te_l1();
    te_l2();
    te_lost();
    do_reset(1'b1);
    nt_l1();
    nt_l2();
    nt_fill();
    nt_down();
    end_sim();
  end
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
